// [pkg/agcr_pkg.sv]
// Constants, bit layout and timing for the global settings register block.
// Assumes the block's own clock is the core clock at 100 MHz.
package agcr_pkg;

    // Register access
    localparam logic [2:0]  GLOBAL_ADDR    = 3'h3;
    localparam int unsigned CFG_W          = 32;
    localparam logic [31:0] GLOBAL_RESET   = 32'h0000_0000;
    localparam logic [31:0] RO_MASK        = 32'h1000_0000;
    localparam logic [31:0] UNMAPPED_READ  = 32'h0000_0000;

    // Field positions
    localparam int B_PSS     = 31;
    localparam int B_PDW     = 30;
    localparam int B_RS      = 29;
    localparam int B_RV      = 28;
    localparam int B_TIE     = 27;
    localparam int B_BSW     = 26;
    localparam int B_VRS     = 25;
    localparam int B_A1      = 24;
    localparam int B_A0      = 23;
    localparam int B_OLS     = 22;
    localparam int B_BUF     = 21;
    localparam int B_OGS     = 20;
    localparam int B_FRS     = 19;
    localparam int B_FILT    = 18;
    localparam int B_TPS     = 17;
    localparam int B_IREF    = 16;
    localparam int B_CSUM    = 15;
    localparam int B_LAT     = 14;
    localparam int B_CLK_HI  = 13;
    localparam int B_CLK_LO  = 12;
    localparam int B_SEQ     = 11;
    localparam int B_DLY_HI  = 10;
    localparam int B_DLY_LO  = 8;
    localparam int B_CH_HI   = 7;
    localparam int B_CH_LO   = 0;

    // Encodings
    localparam logic [1:0] CLK_INT_OUT   = 2'h3;
    localparam logic [2:0] GAIN_UNITY    = 3'h0;
    localparam logic [7:0] CHAN_NONE_SET = 8'h00;
    localparam logic [7:0] CHAN_ZERO     = 8'h01;
    localparam logic [3:0] NO_CHAN       = 4'hF;

    // Timing
    localparam int unsigned CNT_W         = 24;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DLY1_NS       = 32600;
    localparam int unsigned DLY2_NS       = 260000;
    localparam int unsigned DLY3_NS       = 521000;
    localparam int unsigned DLY4_NS       = 1042000;
    localparam int unsigned DLY5_NS       = 4167000;
    localparam int unsigned DLY6_NS       = 16675000;
    localparam int unsigned DLY7_NS       = 66667000;
    localparam int unsigned SETTLE_NOM_CYC = 1280;
    localparam int unsigned SETTLE_FRS_CYC = 1536;
    // Length of a software reset cycle, in clocks
    localparam int unsigned RST_CYCLE_CYC  = 16;
    localparam logic [4:0]  RST_CNT_LOAD   = 5'(RST_CYCLE_CYC);

    // Least time, rounded up to whole cycles, never below one
    function automatic int unsigned ns_to_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction

    localparam int unsigned DLY1_CYC = ns_to_cyc(DLY1_NS);
    localparam int unsigned DLY2_CYC = ns_to_cyc(DLY2_NS);
    localparam int unsigned DLY3_CYC = ns_to_cyc(DLY3_NS);
    localparam int unsigned DLY4_CYC = ns_to_cyc(DLY4_NS);
    localparam int unsigned DLY5_CYC = ns_to_cyc(DLY5_NS);
    localparam int unsigned DLY6_CYC = ns_to_cyc(DLY6_NS);
    localparam int unsigned DLY7_CYC = ns_to_cyc(DLY7_NS);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT,
        SEQ_CONV
    } agcr_seq_state_e;

endpackage

// [logic/agcr_seq.sv]
// Conversion launcher: single setup or automatic channel sequence.
// Assumes the converter datapath pulses i_done once per launched conversion.
`timescale 1ns/1ns
`default_nettype none
module agcr_seq (
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst,
    input  wire logic                     i_clear,
    input  wire logic                     i_start,
    input  wire logic                     i_cal,
    input  wire logic                     i_seq_en,
    input  wire logic [7:0]               i_chan_mask,
    input  wire logic [2:0]               i_cmd_ptr,
    input  wire logic [agcr_pkg::CNT_W-1:0] i_fixed_wait,
    input  wire logic [agcr_pkg::CNT_W-1:0] i_chan_wait,
    input  wire logic                     i_done,
    output logic                          o_go,
    output logic [2:0]                    o_idx,
    output logic                          o_busy
);
    import agcr_pkg::*;

    agcr_seq_state_e    state_ff, nxt_state;
    logic [CNT_W-1:0]   cnt_ff, nxt_cnt;
    logic [2:0]         idx_ff, nxt_idx;
    logic [7:0]         mask_ff, nxt_mask;
    logic               multi_ff, nxt_multi;
    logic               go_ff, nxt_go;
    logic [3:0]         pick;

    // Lowest enabled channel above 'after'; bit 3 says one was found
    function automatic logic [3:0] next_chan(input logic [7:0] m, input logic [3:0] after);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (after == NO_CHAN || 4'(i) > after)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_idx   = idx_ff;
        nxt_mask  = mask_ff;
        nxt_multi = multi_ff;
        nxt_go    = 1'b0;
        pick      = 4'h0;
        case (state_ff)
            SEQ_IDLE: begin
                if (i_start) begin
                    nxt_state = SEQ_WAIT;
                    nxt_mask  = i_chan_mask;
                    if (i_seq_en) begin
                        pick      = next_chan(i_chan_mask, NO_CHAN);
                        nxt_idx   = pick[2:0];
                        nxt_cnt   = i_chan_wait;
                        nxt_multi = ~i_cal;
                    end else begin
                        nxt_idx   = i_cmd_ptr;
                        nxt_cnt   = i_fixed_wait;
                        nxt_multi = 1'b0;
                    end
                end
            end
            SEQ_WAIT: begin
                if (cnt_ff == '0) begin
                    nxt_go    = 1'b1;
                    nxt_state = SEQ_CONV;
                end else begin
                    nxt_cnt = cnt_ff - 1'b1;
                end
            end
            SEQ_CONV: begin
                if (i_done) begin
                    pick = next_chan(mask_ff, {1'b0, idx_ff});
                    if (multi_ff && pick[3]) begin
                        nxt_idx   = pick[2:0];
                        nxt_cnt   = i_chan_wait;
                        nxt_state = SEQ_WAIT;
                    end else begin
                        nxt_state = SEQ_IDLE;
                    end
                end
            end
            default: nxt_state = SEQ_IDLE;
        endcase
        if (i_clear) begin
            nxt_state = SEQ_IDLE;
            nxt_go    = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= SEQ_IDLE;
            cnt_ff   <= '0;
            idx_ff   <= '0;
            mask_ff  <= '0;
            multi_ff <= 1'b0;
            go_ff    <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            idx_ff   <= nxt_idx;
            mask_ff  <= nxt_mask;
            multi_ff <= nxt_multi;
            go_ff    <= nxt_go;
        end
    end

    assign o_go   = go_ff;
    assign o_idx  = idx_ff;
    assign o_busy = (state_ff != SEQ_IDLE);

endmodule // agcr_seq
`default_nettype wire

// [logic/agcr_top.sv]
// Global settings register of a sigma-delta converter, with mode outputs
// and the channel sequencer. Assumes the serial command decoder presents
// register accesses as one-cycle strobes and passes setup register fields in.
//
// Overview of operation
// - Power-save choice picks standby or sleep; power-down bit forces power-down.
// - Writing one to the system reset bit starts a reset cycle.
// - Reset flag reads one after reset; any global register read clears it.
// - Input-tie bit disconnects inputs and ties them at mid-supply.
// - With bridge switch enabled, active latch-zero bit closes or opens switch.
// - Switch follows latch in standby, forced open in sleep.
// - Global latch bits drive pins when selected; reads return actual pin states.
// - Latch source select picks setup-register or global-register latch bits.
// - Buffer on when enabled; bypassed when clear only at unity gain.
// - Calibration pointer source picks input pair or calibration set pointer.
// - Rate scale select multiplies every output data rate by five sixths.
// - Filter bit picks fifth-order plus third-order or first-order sinc.
// - Temperature sensor forces unity gain with buffer on.
// - Reference bit picks external pins or on-chip reference.
// - Checksum bit enables conversion parity; disabled after reset.
// - Zero-latency bit makes each conversion settle in one cycle.
// - Clock select field picks crystal, external, internal, or internal driven out.
// - Sequencer off uses command setup pointer; on uses channel enable bits.
// - Sequencer delay field inserts coded wait before each channel conversion.
// - Several enabled channels convert in sequence, each tagged with channel id.
// - Sequencer on with no channel enabled converts channel zero.
// - Calibration uses only the lowest enabled channel.
// - Setup settling wait applies only with sequencer off; else delay field.
`timescale 1ns/1ns
`default_nettype none
module agcr_top #(
    parameter int unsigned P_DLY2_CYC = agcr_pkg::DLY2_CYC,
    parameter int unsigned P_DLY3_CYC = agcr_pkg::DLY3_CYC,
    parameter int unsigned P_DLY4_CYC = agcr_pkg::DLY4_CYC,
    parameter int unsigned P_DLY5_CYC = agcr_pkg::DLY5_CYC,
    parameter int unsigned P_DLY6_CYC = agcr_pkg::DLY6_CYC,
    parameter int unsigned P_DLY7_CYC = agcr_pkg::DLY7_CYC
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [2:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    output logic [31:0]      o_reg_rdata,
    output logic             o_reg_rvalid,
    input  wire logic        i_setup_latch_one,
    input  wire logic        i_setup_latch_zero,
    input  wire logic [2:0]  i_input_amp_gain,
    input  wire logic [1:0]  i_setup_input_pair,
    input  wire logic [1:0]  i_cal_set_pointer,
    input  wire logic        i_settle_wait_enable,
    input  wire logic [2:0]  i_command_setup_pointer,
    input  wire logic        i_power_save_active,
    input  wire logic        i_conv_start,
    input  wire logic        i_cal_start,
    input  wire logic        i_conv_done,
    input  wire logic        i_internal_clock,
    output logic             o_system_reset_active,
    output logic             o_standby_active,
    output logic             o_sleep_active,
    output logic             o_power_down,
    output logic             o_inputs_tied,
    output logic             o_bridge_switch_closed,
    output logic             o_reference_range_select,
    output logic             o_latch_pin_one_level,
    output logic             o_latch_pin_zero_level,
    output logic             o_input_buffer_on,
    output logic [2:0]       o_effective_gain,
    output logic [1:0]       o_cal_index,
    output logic             o_rate_scale_select,
    output logic             o_filter_sinc1,
    output logic             o_temp_sensor_enable,
    output logic             o_onchip_voltage_ref_enable,
    output logic             o_conversion_parity_enable,
    output logic             o_zero_latency,
    output logic [1:0]       o_clock_select,
    output logic             o_crystal_out_o,
    output logic             o_crystal_out_oe_n,
    output logic             o_conv_go,
    output logic [2:0]       o_setup_index,
    output logic             o_seq_busy
);
    import agcr_pkg::*;

    logic [31:0]      cfg_ff, nxt_cfg;
    logic [4:0]       rst_cnt_ff, nxt_rst_cnt;
    logic [31:0]      rdata_ff, nxt_rdata;
    logic             rvalid_ff, nxt_rvalid;
    logic             pin1_ff, nxt_pin1;
    logic             pin0_ff, nxt_pin0;
    logic             xtal_ff, nxt_xtal;
    logic             hit;
    logic [31:0]      view;
    logic [7:0]       chan_mask;
    logic [CNT_W-1:0] fixed_wait;
    logic [CNT_W-1:0] chan_wait;
    logic             seq_start;

    // Sequencer wait per delay code; code zero means no wait
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [2:0] code);
        logic [CNT_W-1:0] r;
        case (code)
            3'h1:    r = CNT_W'(DLY1_CYC);
            3'h2:    r = CNT_W'(P_DLY2_CYC);
            3'h3:    r = CNT_W'(P_DLY3_CYC);
            3'h4:    r = CNT_W'(P_DLY4_CYC);
            3'h5:    r = CNT_W'(P_DLY5_CYC);
            3'h6:    r = CNT_W'(P_DLY6_CYC);
            3'h7:    r = CNT_W'(P_DLY7_CYC);
            default: r = '0;
        endcase
        return r;
    endfunction

    assign hit = (i_reg_addr == GLOBAL_ADDR);

    // Read view: latch bits show the pins, not the stored value
    always_comb begin
        view       = cfg_ff;
        view[B_A1] = pin1_ff;
        view[B_A0] = pin0_ff;
    end

    // Register file and software reset cycle
    always_comb begin
        nxt_cfg     = cfg_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_rdata   = rdata_ff;
        nxt_rvalid  = 1'b0;
        if (i_reg_rd) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = hit ? view : UNMAPPED_READ;
            if (hit) begin
                nxt_cfg[B_RV] = 1'b0;
            end
        end
        if (rst_cnt_ff != '0) begin
            // Writes during the cycle are dropped; the register is about to clear
            nxt_rst_cnt = rst_cnt_ff - 1'b1;
            if (rst_cnt_ff == 5'h1) begin
                nxt_cfg       = GLOBAL_RESET;
                nxt_cfg[B_RV] = 1'b1;
            end
        end else if (i_reg_wr && hit) begin
            // Flag bit is read-only and keeps its post-read value
            nxt_cfg = (i_reg_wdata & ~RO_MASK) | (nxt_cfg & RO_MASK);
            if (i_reg_wdata[B_RS]) begin
                nxt_rst_cnt = RST_CNT_LOAD;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cfg_ff     <= GLOBAL_RESET | RO_MASK;
            rst_cnt_ff <= '0;
            rdata_ff   <= '0;
            rvalid_ff  <= 1'b0;
        end else begin
            cfg_ff     <= nxt_cfg;
            rst_cnt_ff <= nxt_rst_cnt;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    // Latch pins and crystal output pin
    always_comb begin
        nxt_pin1 = cfg_ff[B_OLS] ? cfg_ff[B_A1] : i_setup_latch_one;
        nxt_pin0 = cfg_ff[B_OLS] ? cfg_ff[B_A0] : i_setup_latch_zero;
        // Gated so the pin stays quiet when not driving the internal clock
        nxt_xtal = (cfg_ff[B_CLK_HI:B_CLK_LO] == CLK_INT_OUT) ? i_internal_clock : 1'b0;
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pin1_ff <= 1'b0;
            pin0_ff <= 1'b0;
            xtal_ff <= 1'b0;
        end else begin
            pin1_ff <= nxt_pin1;
            pin0_ff <= nxt_pin0;
            xtal_ff <= nxt_xtal;
        end
    end

    assign o_reg_rdata           = rdata_ff;
    assign o_reg_rvalid          = rvalid_ff;
    assign o_system_reset_active = (rst_cnt_ff != '0);
    assign o_standby_active      = i_power_save_active & ~cfg_ff[B_PSS];
    assign o_sleep_active        = i_power_save_active & cfg_ff[B_PSS];
    assign o_power_down          = cfg_ff[B_PDW];
    assign o_inputs_tied         = cfg_ff[B_TIE];
    // Sleep wins over the latch; standby leaves it in control
    assign o_bridge_switch_closed = cfg_ff[B_BSW] & pin0_ff & ~o_sleep_active;
    assign o_reference_range_select = cfg_ff[B_VRS];
    assign o_latch_pin_one_level  = pin1_ff;
    assign o_latch_pin_zero_level = pin0_ff;
    assign o_effective_gain = cfg_ff[B_TPS] ? GAIN_UNITY : i_input_amp_gain;
    assign o_input_buffer_on = cfg_ff[B_TPS] | cfg_ff[B_BUF]
                             | (i_input_amp_gain != GAIN_UNITY);
    assign o_cal_index = cfg_ff[B_OGS] ? i_cal_set_pointer : i_setup_input_pair;
    assign o_rate_scale_select         = cfg_ff[B_FRS];
    assign o_filter_sinc1              = cfg_ff[B_FILT];
    assign o_temp_sensor_enable        = cfg_ff[B_TPS];
    assign o_onchip_voltage_ref_enable = cfg_ff[B_IREF];
    assign o_conversion_parity_enable  = cfg_ff[B_CSUM];
    assign o_zero_latency              = cfg_ff[B_LAT];
    assign o_clock_select     = cfg_ff[B_CLK_HI:B_CLK_LO];
    assign o_crystal_out_o    = xtal_ff;
    assign o_crystal_out_oe_n = (cfg_ff[B_CLK_HI:B_CLK_LO] != CLK_INT_OUT);

    // Sequencer setup
    always_comb begin
        chan_mask = cfg_ff[B_CH_HI:B_CH_LO];
        if (chan_mask == CHAN_NONE_SET) begin
            chan_mask = CHAN_ZERO;
        end
        // Settling wait counted in core clocks, longer when rates are scaled
        if (i_settle_wait_enable) begin
            fixed_wait = cfg_ff[B_FRS] ? CNT_W'(SETTLE_FRS_CYC) : CNT_W'(SETTLE_NOM_CYC);
        end else begin
            fixed_wait = '0;
        end
        chan_wait = delay_cycles(cfg_ff[B_DLY_HI:B_DLY_LO]);
        seq_start = (i_conv_start | i_cal_start) & ~o_system_reset_active;
    end

    agcr_seq u_seq (
        .i_mclk       (i_mclk),
        .i_rst        (i_rst),
        .i_clear      (o_system_reset_active),
        .i_start      (seq_start),
        .i_cal        (i_cal_start),
        .i_seq_en     (cfg_ff[B_SEQ]),
        .i_chan_mask  (chan_mask),
        .i_cmd_ptr    (i_command_setup_pointer),
        .i_fixed_wait (fixed_wait),
        .i_chan_wait  (chan_wait),
        .i_done       (i_conv_done),
        .o_go         (o_conv_go),
        .o_idx        (o_setup_index),
        .o_busy       (o_seq_busy)
    );

endmodule // agcr_top
`default_nettype wire

// [testbench/agcr_conv_model.sv]
// Datapath stand-in: a done pulse per launch.
// Assumes a nonzero, steady i_lat.
`timescale 1ns/1ns
`default_nettype none
module agcr_conv_model (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_go,
    input  wire logic [3:0] i_lat,
    output logic            o_done
);
    logic [3:0] cnt;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 4'h0;
            o_done <= 1'b0;
        end else begin
            o_done <= (cnt == 4'h1);
            if (i_go)
                cnt <= i_lat;
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule // agcr_conv_model
`default_nettype wire

// [testbench/agcr_top_props.sv]
// Port checker for the global settings block.
// Bound to agcr_top; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module agcr_top_props (
    input wire logic        i_mclk,
    input wire logic        i_rst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [2:0]  i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic [31:0] o_reg_rdata,
    input wire logic        o_reg_rvalid,
    input wire logic        o_system_reset_active,
    input wire logic        o_sleep_active,
    input wire logic        o_power_down,
    input wire logic        o_inputs_tied,
    input wire logic        o_bridge_switch_closed,
    input wire logic        o_latch_pin_zero_level,
    input wire logic        o_input_buffer_on,
    input wire logic [2:0]  o_effective_gain,
    input wire logic        o_temp_sensor_enable,
    input wire logic [1:0]  o_clock_select,
    input wire logic        o_crystal_out_oe_n,
    input wire logic        o_conv_go,
    input wire logic        o_seq_busy
);
    import agcr_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    property p_rd_answer;
        i_reg_rd |=> o_reg_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    // Quiet gap: a reset-cycle end sets the flag again
    property p_flag_clear;
        (i_reg_rd && i_reg_addr == GLOBAL_ADDR && !o_system_reset_active) ##1
        !o_system_reset_active ##1 (i_reg_rd && i_reg_addr == GLOBAL_ADDR) |=> !o_reg_rdata[B_RV];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag kept");
    property p_rst_start;
        i_reg_wr && i_reg_addr == GLOBAL_ADDR && i_reg_wdata[B_RS] && !o_system_reset_active
        |=> o_system_reset_active;
    endproperty
    a_rst_start: assert property (p_rst_start) else $error("no reset cycle");
    property p_rst_len;
        $rose(o_system_reset_active) |-> o_system_reset_active[*8] ##1
        o_system_reset_active[*8] ##1 !o_system_reset_active;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset length");
    property p_rst_end;
        $fell(o_system_reset_active) |-> !o_power_down && !o_inputs_tied && o_clock_select == 2'h0;
    endproperty
    a_rst_end: assert property (p_rst_end) else $error("register not cleared");
    property p_sleep_open;
        o_sleep_active |-> !o_bridge_switch_closed;
    endproperty
    a_sleep_open: assert property (p_sleep_open) else $error("switch in sleep");
    property p_switch;
        o_bridge_switch_closed |-> o_latch_pin_zero_level;
    endproperty
    a_switch: assert property (p_switch) else $error("switch without latch");
    property p_temp;
        o_temp_sensor_enable |-> o_effective_gain == GAIN_UNITY && o_input_buffer_on;
    endproperty
    a_temp: assert property (p_temp) else $error("sensor gain not forced");
    property p_bypass;
        !o_input_buffer_on |-> o_effective_gain == GAIN_UNITY;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass at gain");
    property p_xtal;
        o_clock_select != CLK_INT_OUT && $stable(o_clock_select) |-> o_crystal_out_oe_n;
    endproperty
    a_xtal: assert property (p_xtal) else $error("clock pin driven");
    property p_go;
        o_conv_go |-> o_seq_busy ##1 !o_conv_go;
    endproperty
    a_go: assert property (p_go) else $error("launch pulse wrong");
endmodule // agcr_top_props
bind agcr_top agcr_top_props i_agcr_top_props (.*);
`default_nettype wire

// [testbench/adc_global_config_register_bench.sv]
// Self-checking bench for the global settings block.
// Assumes short delay parameters and the datapath stand-in.
`timescale 1ns/1ns
`default_nettype none
module adc_global_config_register_bench;
    import agcr_pkg::*;
    logic        i_mclk, i_rst, i_reg_wr, i_reg_rd, i_setup_latch_one, i_setup_latch_zero;
    logic        i_settle_wait_enable, i_power_save_active, i_conv_start, i_cal_start;
    logic        i_conv_done, i_internal_clock, o_reg_rvalid, o_system_reset_active;
    logic        o_standby_active, o_sleep_active, o_power_down, o_inputs_tied;
    logic        o_bridge_switch_closed, o_reference_range_select, o_latch_pin_one_level;
    logic        o_latch_pin_zero_level, o_input_buffer_on, o_rate_scale_select;
    logic        o_filter_sinc1, o_temp_sensor_enable, o_onchip_voltage_ref_enable;
    logic        o_conversion_parity_enable, o_zero_latency, o_crystal_out_o;
    logic        o_crystal_out_oe_n, o_conv_go, o_seq_busy, sl;
    logic [2:0]  i_reg_addr, i_input_amp_gain, i_command_setup_pointer, o_effective_gain;
    logic [2:0]  o_setup_index;
    logic [1:0]  i_setup_input_pair, i_cal_set_pointer, o_cal_index, o_clock_select, pins;
    logic [31:0] i_reg_wdata, o_reg_rdata, d;
    logic [3:0]  lat;
    logic [31:0] exp_rd[$];
    logic [2:0]  exp_ix[$];
    int          n_errors, n_tests, seed, cyc, k;

    agcr_top #(.P_DLY3_CYC(30), .P_DLY4_CYC(40), .P_DLY5_CYC(50),
        .P_DLY6_CYC(60), .P_DLY7_CYC(70)) i_agcr_top (.*);
    agcr_conv_model i_agcr_conv_model (.i_mclk, .i_rst, .i_go(o_conv_go), .i_lat(lat),
        .o_done(i_conv_done));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task wr(input logic [31:0] v);
        @(negedge i_mclk);
        i_reg_wr = 1'b1;
        i_reg_addr = GLOBAL_ADDR;
        i_reg_wdata = v;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask
    task rd(input logic [2:0] a, input logic [31:0] e);
        @(negedge i_mclk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        exp_rd.push_back(e);
        @(negedge i_mclk);
        i_reg_rd = 1'b0;
    endtask
    task launch(input logic [31:0] v, input logic cal, input int w);
        int m;
        wr(v);
        @(negedge i_mclk);
        {i_cal_start, i_conv_start} = cal ? 2'b10 : 2'b01;
        @(negedge i_mclk);
        {i_cal_start, i_conv_start} = 2'b00;
        for (m = 0; o_conv_go !== 1'b1 && m < 30000; m++) @(negedge i_mclk);
        chk(32'(m), 32'(w + 1));
        for (m = 0; o_seq_busy !== 1'b0 && m < 30000; m++) @(negedge i_mclk);
        chk(32'(exp_ix.size()), 32'h0);
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Surplus result meets an unknown
    always @(posedge i_mclk) begin
        #1;
        if (o_reg_rvalid === 1'b1)
            chk(o_reg_rdata, exp_rd.size() > 0 ? exp_rd.pop_front() : 32'hX);
        if (o_conv_go === 1'b1)
            chk(32'(o_setup_index), exp_ix.size() > 0 ? 32'(exp_ix.pop_front()) : 32'hX);
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    initial begin
        seed = 47050;
        lat = 4'h5;
        {i_reg_wr, i_reg_rd, i_setup_latch_one, i_setup_latch_zero, i_input_amp_gain,
            i_settle_wait_enable, i_power_save_active, i_conv_start, i_cal_start} = '0;
        i_rst = 1'b1;
        repeat (4) @(negedge i_mclk);
        i_rst = 1'b0;
        rd(GLOBAL_ADDR, 32'h1000_0000);
        rd(GLOBAL_ADDR, 32'h0000_0000);
        rd(3'h5, UNMAPPED_READ);
        repeat (24) begin
            d = $random(seed);
            d[29:28] = 2'b00;
            {i_setup_latch_one, i_setup_latch_zero, i_input_amp_gain, i_setup_input_pair,
                i_cal_set_pointer, i_power_save_active, i_internal_clock} = 11'($random(seed));
            i_input_amp_gain[0] &= ~&i_input_amp_gain;
            wr(d);
            repeat (2) @(negedge i_mclk);
            pins = d[22] ? d[24:23] : {i_setup_latch_one, i_setup_latch_zero};
            sl = i_power_save_active & d[31];
            chk(32'({o_power_down, o_inputs_tied, o_reference_range_select, o_latch_pin_one_level,
                o_latch_pin_zero_level, o_rate_scale_select, o_filter_sinc1, o_temp_sensor_enable,
                o_onchip_voltage_ref_enable, o_conversion_parity_enable, o_zero_latency,
                o_clock_select, o_sleep_active, o_standby_active, o_bridge_switch_closed,
                o_input_buffer_on, o_effective_gain, o_cal_index, o_crystal_out_oe_n}),
                32'({d[30], d[27], d[25], pins, d[19:14], d[13:12], sl,
                i_power_save_active & ~d[31], d[26] & pins[0] & ~sl,
                d[17] | d[21] | (i_input_amp_gain != 3'h0), d[17] ? 3'h0 : i_input_amp_gain,
                d[20] ? i_cal_set_pointer : i_setup_input_pair, d[13:12] != 2'h3}));
            rd(GLOBAL_ADDR, {d[31:25], pins, d[22:0]});
        end
        wr(32'h6000_3000);
        wr(32'h4000_0000);
        for (k = 0; o_system_reset_active === 1'b1 && k < 40; k++) @(negedge i_mclk);
        chk(32'(k), 32'(RST_CYCLE_CYC - 2));
        rd(GLOBAL_ADDR, 32'h1000_0000);
        exp_ix = '{3'h0, 3'h2, 3'h5, 3'h7};
        launch(32'h0000_08A5, 1'b0, 0);
        exp_ix = '{3'h0};
        launch(32'h0000_0800, 1'b0, 0);
        exp_ix = '{3'h2};
        launch(32'h0000_08A4, 1'b1, 0);
        i_command_setup_pointer = 3'h5;
        i_settle_wait_enable = 1'b1;
        exp_ix = '{3'h5};
        launch(32'h0000_00A4, 1'b0, SETTLE_NOM_CYC);
        exp_ix = '{3'h5};
        launch(32'h0008_0000, 1'b0, SETTLE_FRS_CYC);
        for (k = 2; k < 8; k++) begin
            lat = 4'($random(seed)) | 4'h1;
            exp_ix = '{3'h0, 3'h7};
            launch(32'h0000_0881 | 32'(k << 8), 1'b0, k == 2 ? DLY2_CYC : 10 * k);
        end
        repeat (4) @(negedge i_mclk);
        tally_and_finish();
    end
endmodule // adc_global_config_register_bench
`default_nettype wire
